// ### rtl/ics_pkg.sv
// ics_pkg: constants and carrier types of the channel switch slave port.
// assumes: one upstream master, bus clock far below the system clock.
//
// Notes on behaviour
// - idle bus leaves both lines released high
// - one bit per clock, sampled while high
// - data steady while clock high
// - data falling while clock high is START
// - data rising while clock high is STOP
// - no limit on bytes per transaction
// - eight data bits then one acknowledge slot
// - transmitter releases data during ninth clock
// - addressed receiver acknowledges every byte
// - acknowledger holds data low through slot
// - after not-acknowledge device releases data
// - write: address, direction zero, control byte
// - read: address, direction one, byte returned
// - address bit zero selects read or write
// - last written byte wins
// - low four bits enable channels one each
// - new selection applies after STOP
package ics_pkg;
    // byte framing
    localparam logic [3:0] ICS_BIT_LAST = 4'h7;
    localparam logic [3:0] ICS_BIT_ACK = 4'h8;
    localparam logic [3:0] ICS_BIT_RESUME = 4'h2;
    localparam logic [3:0] ICS_BIT_FIRST = 4'h0;
    // control register
    localparam int ICS_CH_N = 4;
    localparam logic [7:0] ICS_CTRL_RESET = 8'h00;
    localparam logic ICS_DIR_READ = 1'b1;
    // fixed upper address bits; the value is arbitrary
    localparam logic [3:0] ICS_ADDR_FIXED_DEF = 4'h7;
    localparam int ICS_ADDR_PIN_N = 3;
    // line spike filter
    localparam int ICS_CLK_NS = 10;
    localparam int ICS_SPIKE_NS = 20;
    localparam int ICS_SPIKE_CYC =
        (ICS_SPIKE_NS / ICS_CLK_NS) < 1 ? 1 : ICS_SPIKE_NS / ICS_CLK_NS;
    localparam logic [3:0] ICS_SPIKE_CNT = 4'(ICS_SPIKE_CYC);
    localparam logic [1:0] ICS_LINE_IDLE = 2'b11;

    typedef enum logic [1:0] {
        ICS_ST_IGNORE = 2'b00,
        ICS_ST_ADDR = 2'b01,
        ICS_ST_WRITE = 2'b10,
        ICS_ST_READ = 2'b11
    } ics_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } ics_line_t;

    typedef struct packed {
        logic start;
        logic stop;
    } ics_cond_t;
endpackage

// ### rtl/ics_sync.sv
// ics_sync: two flip-flop level synchroniser.
// assumes: d changes slowly compared with clk; reset is synchronous.
`timescale 1ns/1ps
module ics_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ### rtl/ics_xfer.sv
// ics_xfer: moves a word from the bus clock domain to the system domain.
// assumes: src_load pulses are many dst clocks apart; the source clock
// may stop after a load, so the word is held until the next load.
`timescale 1ns/1ps
module ics_xfer #(
    parameter int W = 8
) (
    input wire logic src_clk,
    input wire logic src_load,
    input wire logic [W-1:0] src_data,
    input wire logic dst_clk,
    input wire logic dst_rst,
    output logic dst_pulse,
    output logic [W-1:0] dst_data
);
    // bus clock flops have no reset: the bus clock may never run in reset
    logic src_tgl_q = 1'b0;
    logic [W-1:0] src_word_q = '0;
    logic tgl_s;
    logic tgl_prev_q;
    logic evt;

    always_ff @(posedge src_clk) begin
        if (src_load) begin
            src_word_q <= src_data;
            src_tgl_q <= ~src_tgl_q;
        end
    end

    ics_sync #(.W(1), .RST_VAL(1'b0)) u_tgl (
        .clk(dst_clk),
        .rst(dst_rst),
        .d(src_tgl_q),
        .q(tgl_s)
    );

    assign evt = tgl_s ^ tgl_prev_q;

    // the word has been stable for two dst clocks when the toggle lands
    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            tgl_prev_q <= 1'b0;
            dst_pulse <= 1'b0;
            dst_data <= '0;
        end else begin
            tgl_prev_q <= tgl_s;
            dst_pulse <= evt;
            if (evt) begin
                dst_data <= src_word_q;
            end
        end
    end
endmodule

// ### rtl/ics_switch.sv
// ics_switch: serial slave port and control byte of a four-channel switch.
// assumes: scl_clk is the upstream bus clock pin, also used as the link
// clock; sda is open drain with an external pull-up; addr_i is strapped.
`timescale 1ns/1ps
module ics_switch #(
    parameter logic [3:0] ADDR_FIXED = ics_pkg::ICS_ADDR_FIXED_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic reset_n_i,
    input wire logic [ics_pkg::ICS_ADDR_PIN_N-1:0] addr_i,
    output logic [ics_pkg::ICS_CH_N-1:0] chan_en,
    output logic [7:0] ctrl_byte,
    output logic wr_pending,
    output logic bus_busy
);
    // ==================================================================
    // declarations
    // ==================================================================
    ics_pkg::ics_line_t line_s;
    ics_pkg::ics_line_t filt_q;
    ics_pkg::ics_line_t prev_q;
    ics_pkg::ics_cond_t cond;
    logic [3:0] stab_cnt_q;
    logic line_moved;
    logic line_stable;
    logic rstn_s;
    logic [ics_pkg::ICS_ADDR_PIN_N-1:0] addr_s;
    logic clr;
    logic start_tgl_q = 1'b0;
    logic frame_q;
    logic live_q;
    logic beg_s;
    logic beg_prev_q;
    logic begin_evt;
    logic wr_evt;
    logic [7:0] wr_byte;
    logic [7:0] pend_q;
    logic pend_v_q;
    logic [7:0] ctrl_q;
    logic [ics_pkg::ICS_CH_N-1:0] chan_q;
    logic accept_wr;
    logic [7:0] commit_byte;

    // link domain, clocked by the bus clock; initial values stand in for
    // a reset because the bus clock does not run while the bus is idle
    logic st_a_q = 1'b0;
    logic st_b_q = 1'b0;
    logic seen_q = 1'b0;
    logic beg_tgl_q = 1'b0;
    logic [7:0] sh_q = 8'h00;
    logic [7:0] tx_q = 8'h00;
    logic [3:0] cnt_q = 4'h0;
    logic ack_q = 1'b0;
    logic drive_q = 1'b0;
    ics_pkg::ics_state_t state_q = ics_pkg::ICS_ST_IGNORE;
    ics_pkg::ics_state_t state_d;
    logic [3:0] cnt_d;
    logic ack_d;
    logic [7:0] tx_d;
    logic new_frame;
    logic [7:0] rx_byte;
    logic at_last;
    logic at_ack;
    logic addr_hit;
    logic wr_fire;
    logic drive_d;

    // ==================================================================
    // pin synchronisers (system domain)
    // ==================================================================
    ics_sync #(.W(2), .RST_VAL(ics_pkg::ICS_LINE_IDLE)) u_line (
        .clk(clk_sys),
        .rst(rst),
        .d({scl_clk, sda_i}),
        .q(line_s)
    );

    ics_sync #(
        .W(ics_pkg::ICS_ADDR_PIN_N + 1),
        .RST_VAL('1)
    ) u_cfg (
        .clk(clk_sys),
        .rst(rst),
        .d({reset_n_i, addr_i}),
        .q({rstn_s, addr_s})
    );

    // the reset pin clears the frame and control registers as power-on reset does
    assign clr = rst || !rstn_s;

    // ==================================================================
    // spike filter on the synchronised lines
    // ==================================================================
    assign line_moved = (line_s != filt_q);
    assign line_stable = (stab_cnt_q == ics_pkg::ICS_SPIKE_CNT);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stab_cnt_q <= 4'h0;
            filt_q <= ics_pkg::ICS_LINE_IDLE;
        end else if (!line_moved) begin
            stab_cnt_q <= 4'h0;
        end else if (line_stable) begin
            stab_cnt_q <= 4'h0;
            filt_q <= line_s;
        end else begin
            stab_cnt_q <= stab_cnt_q + 4'h1;
        end
    end

    // ==================================================================
    // START and STOP detection
    // ==================================================================
    assign cond.start = prev_q.scl && filt_q.scl &&
                        prev_q.sda && !filt_q.sda;
    assign cond.stop = prev_q.scl && filt_q.scl &&
                       !prev_q.sda && filt_q.sda;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prev_q <= ics_pkg::ICS_LINE_IDLE;
        end else begin
            prev_q <= filt_q;
        end
    end

    // ==================================================================
    // frame tracking
    // ==================================================================
    ics_sync #(.W(1), .RST_VAL(1'b0)) u_beg (
        .clk(clk_sys),
        .rst(rst),
        .d(beg_tgl_q),
        .q(beg_s)
    );

    assign begin_evt = beg_s ^ beg_prev_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            beg_prev_q <= 1'b0;
        end else begin
            beg_prev_q <= beg_s;
        end
    end

    // no reset: the link side keeps its copy of this toggle across rst
    always_ff @(posedge clk_sys) begin
        if (cond.start) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    // frame_q: between START and STOP; live_q: link engine has taken the
    // frame, so its drive and its write events can be trusted
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            frame_q <= 1'b0;
            live_q <= 1'b0;
        end else if (cond.stop) begin
            frame_q <= 1'b0;
            live_q <= 1'b0;
        end else if (cond.start) begin
            frame_q <= 1'b1;
            live_q <= 1'b0;
        end else if (begin_evt && frame_q) begin
            live_q <= 1'b1;
        end
    end

    // ==================================================================
    // control byte
    // ==================================================================
    ics_xfer #(.W(8)) u_wr (
        .src_clk(scl_clk),
        .src_load(wr_fire),
        .src_data(rx_byte),
        .dst_clk(clk_sys),
        .dst_rst(rst),
        .dst_pulse(wr_evt),
        .dst_data(wr_byte)
    );

    assign accept_wr = wr_evt && live_q;
    // a byte landing with the STOP is still committed
    assign commit_byte = accept_wr ? wr_byte : pend_q;

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            pend_q <= ics_pkg::ICS_CTRL_RESET;
            pend_v_q <= 1'b0;
            ctrl_q <= ics_pkg::ICS_CTRL_RESET;
        end else if (cond.stop) begin
            pend_v_q <= 1'b0;
            if (pend_v_q || accept_wr) begin
                ctrl_q <= commit_byte;
            end
        end else if (accept_wr) begin
            pend_q <= wr_byte;
            pend_v_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (clr) begin
            chan_q <= '0;
        end else begin
            chan_q <= ctrl_q[ics_pkg::ICS_CH_N-1:0];
        end
    end

    assign chan_en = chan_q;
    assign ctrl_byte = ctrl_q;
    assign wr_pending = pend_v_q;
    assign bus_busy = frame_q;

    // ==================================================================
    // link engine (bus clock domain)
    // ==================================================================
    // START crossing: first stage on the falling edge, second on the
    // rising edge; the first address bit is kept in sh_q meanwhile
    always_ff @(negedge scl_clk) begin
        st_a_q <= start_tgl_q;
    end

    always_ff @(posedge scl_clk) begin
        st_b_q <= st_a_q;
    end

    assign new_frame = st_b_q ^ seen_q;
    assign rx_byte = {sh_q[6:0], sda_i};
    assign at_last = (cnt_q == ics_pkg::ICS_BIT_LAST);
    assign at_ack = (cnt_q == ics_pkg::ICS_BIT_ACK);
    assign addr_hit = (rx_byte[7:1] == {ADDR_FIXED, addr_s});
    assign wr_fire = !new_frame && at_last &&
                     (state_q == ics_pkg::ICS_ST_WRITE);

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q + 4'h1;
        ack_d = ack_q;
        tx_d = tx_q;
        if (new_frame) begin
            state_d = ics_pkg::ICS_ST_ADDR;
            cnt_d = ics_pkg::ICS_BIT_RESUME;
            ack_d = 1'b0;
        end else if (at_ack) begin
            cnt_d = ics_pkg::ICS_BIT_FIRST;
            ack_d = 1'b0;
            if (state_q == ics_pkg::ICS_ST_READ && !ack_q && sda_i) begin
                state_d = ics_pkg::ICS_ST_IGNORE;
            end
        end else begin
            if (state_q == ics_pkg::ICS_ST_READ) begin
                tx_d = {tx_q[6:0], tx_q[7]};
            end
            if (at_last) begin
                cnt_d = ics_pkg::ICS_BIT_ACK;
                case (state_q)
                    ics_pkg::ICS_ST_ADDR: begin
                        if (addr_hit) begin
                            ack_d = 1'b1;
                            tx_d = ctrl_q;
                            if (rx_byte[0] == ics_pkg::ICS_DIR_READ) begin
                                state_d = ics_pkg::ICS_ST_READ;
                            end else begin
                                state_d = ics_pkg::ICS_ST_WRITE;
                            end
                        end else begin
                            state_d = ics_pkg::ICS_ST_IGNORE;
                        end
                    end
                    ics_pkg::ICS_ST_WRITE: begin
                        ack_d = 1'b1;
                    end
                    default: begin
                        ack_d = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge scl_clk) begin
        sh_q <= rx_byte;
        state_q <= state_d;
        cnt_q <= cnt_d;
        ack_q <= ack_d;
        tx_q <= tx_d;
        if (new_frame) begin
            seen_q <= st_b_q;
            beg_tgl_q <= ~beg_tgl_q;
        end
    end

    // ==================================================================
    // data line drive
    // ==================================================================
    // changes only on the falling edge so data is steady while scl high
    always_comb begin
        if (at_ack) begin
            drive_d = ack_q;
        end else if (state_q == ics_pkg::ICS_ST_READ) begin
            drive_d = !tx_q[7];
        end else begin
            drive_d = 1'b0;
        end
    end

    always_ff @(negedge scl_clk) begin
        drive_q <= drive_d;
    end

    // the system-domain gate releases the line at once on reset or STOP
    assign sda_oe = drive_q && live_q;
    assign sda_o = 1'b0;
endmodule

// ### tb/ics_switch_monitor.sv
// ics_switch_monitor: pin-level timing checks for ics_switch.
// assumes: bound to ics_switch; everything sampled on clk_sys.
`timescale 1ns/1ps
module ics_switch_monitor #(
    parameter logic [3:0] ADDR_FIXED = ics_pkg::ICS_ADDR_FIXED_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl_clk,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic reset_n_i,
    input wire logic [ics_pkg::ICS_ADDR_PIN_N-1:0] addr_i,
    input wire logic [ics_pkg::ICS_CH_N-1:0] chan_en,
    input wire logic [7:0] ctrl_byte,
    input wire logic wr_pending,
    input wire logic bus_busy
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ==========================================
    // properties
    property p_chan;
        $past(reset_n_i, 3) |-> chan_en == $past(ctrl_byte[3:0]);
    endproperty
    a_chan: assert property (p_chan)
        else $error("chan_en does not follow ctrl_byte");
    property p_commit;
        $changed(ctrl_byte) && ctrl_byte != 8'h00 |-> $past(wr_pending);
    endproperty
    a_commit: assert property (p_commit)
        else $error("ctrl_byte changed with no pending write");
    property p_rstn;
        !reset_n_i [*4] |=> ctrl_byte == 8'h00 && !wr_pending
            && !bus_busy && !sda_oe ##1 chan_en == 4'h0;
    endproperty
    a_rstn: assert property (p_rstn)
        else $error("reset pin did not clear state");
    property p_idle;
        !bus_busy |-> !sda_oe;
    endproperty
    a_idle: assert property (p_idle)
        else $error("data driven while bus idle");
    property p_oe_low;
        $changed(sda_oe) |-> !scl_clk;
    endproperty
    a_oe_low: assert property (p_oe_low)
        else $error("data drive changed while clock high");
    property p_ack;
        $rose(sda_oe) |-> sda_oe [*8];
    endproperty
    a_ack: assert property (p_ack)
        else $error("data drive too short");
    property p_start;
        $rose(bus_busy) |-> scl_clk && !sda_i;
    endproperty
    a_start: assert property (p_start)
        else $error("busy rose without start");
    property p_stop;
        $fell(bus_busy) && reset_n_i |-> scl_clk && sda_i;
    endproperty
    a_stop: assert property (p_stop)
        else $error("busy fell without stop");
    property p_pend;
        $rose(wr_pending) |-> bus_busy;
    endproperty
    a_pend: assert property (p_pend)
        else $error("pending write outside a frame");
    c_commit: cover property ($fell(wr_pending));
    c_drive: cover property (bus_busy && sda_oe);
    c_rstn: cover property (!reset_n_i [*4]);
endmodule

bind ics_switch ics_switch_monitor #(.ADDR_FIXED(ADDR_FIXED)) mon_u (
    .clk_sys(clk_sys), .rst(rst), .scl_clk(scl_clk), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .reset_n_i(reset_n_i),
    .addr_i(addr_i), .chan_en(chan_en), .ctrl_byte(ctrl_byte),
    .wr_pending(wr_pending), .bus_busy(bus_busy));

// ### tb/ics_master_model.sv
// ics_master_model: behavioural upstream bus master, time based.
// assumes: data line resolved outside with a pull-up; clock idles high.
`timescale 1ns/1ps
module ics_master_model #(
    parameter int Q = 20,
    // hold around START and STOP, long enough for the line filter
    parameter int H = 150
) (
    output logic scl_line,
    output logic sda_low,
    input wire logic sda_line
);
    // low phase before a data change; raise it for a slow master
    int lo_ns = Q;
    initial begin
        scl_line = 1'b1;
        sda_low = 1'b0;
    end
    // ==========================================
    // frame tasks
    task automatic start_c();
        #3 sda_low = 1'b0;
        scl_line = 1'b1;
        #(H) sda_low = 1'b1;
        #(H) scl_line = 1'b0;
    endtask
    // nine bit slots: eight data bits then the acknowledge slot
    task automatic xb(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            #(lo_ns) sda_low = !d[i];
            #(Q) scl_line = 1'b1;
            #(Q) r[i] = sda_line;
            #(Q) scl_line = 1'b0;
        end
    endtask
    task automatic stop_c();
        #(lo_ns) sda_low = 1'b1;
        #(Q) scl_line = 1'b1;
        #(H) sda_low = 1'b0;
        #(H);
    endtask
endmodule

// ### tb/testbench.sv
// testbench: drives the switch slave port through the master model.
// assumes: open-drain data line with pull-up resolved here.
`timescale 1ns/1ps
module testbench;
    localparam logic [2:0] ADR = 3'h5;
    localparam logic [7:0] WADR = {ics_pkg::ICS_ADDR_FIXED_DEF, ADR, 1'b0};
    localparam logic [7:0] RADR = WADR | 8'h01;
    logic clk_sys;
    logic rst;
    logic reset_n_i;
    logic [2:0] addr_i;
    logic sda_o;
    logic sda_oe;
    logic [3:0] chan_en;
    logic [7:0] ctrl_byte;
    logic wr_pending;
    logic bus_busy;
    logic scl_line;
    logic m_low;
    logic [8:0] r;
    logic [7:0] v;
    int num_errors = 0;
    int checks = 0;
    wire sda_line = !(sda_oe || m_low);

    ics_switch dut_u (
        .clk_sys(clk_sys), .rst(rst), .scl_clk(scl_line),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .reset_n_i(reset_n_i), .addr_i(addr_i), .chan_en(chan_en),
        .ctrl_byte(ctrl_byte), .wr_pending(wr_pending),
        .bus_busy(bus_busy));
    ics_master_model mst_u (
        .scl_line(scl_line), .sda_low(m_low), .sda_line(sda_line));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // ==========================================
    // helpers
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic put(input logic [7:0] b);
        mst_u.xb({b, 1'b1}, r);
        check("ack", {7'h00, r[0]}, 8'h00);
    endtask
    task automatic get(input logic nack);
        mst_u.xb({8'hff, nack}, r);
        v = r[8:1];
    endtask
    task automatic wr_ctrl(input logic [7:0] d);
        mst_u.start_c();
        put(WADR);
        put(d);
        mst_u.stop_c();
        @(posedge clk_sys);
    endtask
    task automatic summarize();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        num_errors++;
        summarize();
    end
    // ==========================================
    // scenarios
    initial begin
        rst <= 1'b1;
        reset_n_i <= 1'b1;
        addr_i <= ADR;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (10) @(posedge clk_sys);
        check("ctrl_byte", ctrl_byte, 8'h00);
        check("chan_en", {4'h0, chan_en}, 8'h00);
        mst_u.start_c();
        mst_u.xb({WADR ^ 8'h04, 1'b1}, r);
        check("foreign_ack", {7'h00, r[0]}, 8'h01);
        mst_u.xb({8'h0f, 1'b1}, r);
        mst_u.stop_c();
        check("ctrl_byte", ctrl_byte, 8'h00);
        mst_u.start_c();
        put(WADR);
        put(8'ha5);
        put(8'h3c);
        put(8'h96);
        check("wr_pending", {7'h00, wr_pending}, 8'h01);
        check("ctrl_byte", ctrl_byte, 8'h00);
        check("bus_busy", {7'h00, bus_busy}, 8'h01);
        mst_u.stop_c();
        @(posedge clk_sys);
        check("ctrl_byte", ctrl_byte, 8'h96);
        check("chan_en", {4'h0, chan_en}, 8'h06);
        check("bus_busy", {7'h00, bus_busy}, 8'h00);
        check("sda_o", {7'h00, sda_o}, 8'h00);
        mst_u.start_c();
        put(RADR);
        get(1'b0);
        check("rd_byte", v, 8'h96);
        get(1'b1);
        check("rd_again", v, 8'h96);
        @(posedge clk_sys);
        check("sda_oe", {7'h00, sda_oe}, 8'h00);
        mst_u.stop_c();
        for (int i = 0; i < 4; i++) begin
            mst_u.lo_ns = (i == 2) ? 400 : 20;
            wr_ctrl(8'hf0 | (8'h01 << i));
            check("chan_en", {4'h0, chan_en}, 8'h01 << i);
            mst_u.start_c();
            put(RADR);
            get(1'b1);
            check("rd_byte", v, 8'hf0 | (8'h01 << i));
            mst_u.stop_c();
        end
        reset_n_i <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check("ctrl_byte", ctrl_byte, 8'h00);
        check("chan_en", {4'h0, chan_en}, 8'h00);
        reset_n_i <= 1'b1;
        repeat (8) @(posedge clk_sys);
        wr_ctrl(8'h0b);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        check("ctrl_byte", ctrl_byte, 8'h00);
        repeat (10) @(posedge clk_sys);
        wr_ctrl(8'h05);
        check("chan_en", {4'h0, chan_en}, 8'h05);
        summarize();
    end
endmodule
